// File: verilog/rsd_pkg.sv
// shared constants for the relative seek and state dump controller
// assumes a 200 MHz clock and one command byte stream from the host end
package rsd_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_SEEK    = 8'h0F;
	localparam logic [7:0] OP_REL     = 8'h8F;
	localparam logic [7:0] REL_MASK   = 8'hBF;
	localparam int         REL_DIR    = 6;
	localparam logic [7:0] OP_RECAL   = 8'h07;
	localparam logic [7:0] OP_DUMP    = 8'h0E;
	localparam logic [7:0] OP_SENSE   = 8'h08;
	localparam logic [7:0] OP_SPECIFY = 8'h03;
	localparam logic [7:0] OP_CONFIG  = 8'h13;
	localparam logic [7:0] LOW5_MASK  = 8'h1F;
	localparam logic [7:0] OP_FORMAT  = 8'h0D;
	localparam logic [7:0] OP_READ    = 8'h06;
	localparam logic [7:0] OP_WRITE   = 8'h05;
	typedef enum logic [3:0] {
		OPC_SEEK  = 4'h0,
		OPC_REL   = 4'h1,
		OPC_RECAL = 4'h2,
		OPC_DUMP  = 4'h3,
		OPC_SENSE = 4'h4,
		OPC_SPEC  = 4'h5,
		OPC_CONF  = 4'h6,
		OPC_FMT   = 4'h7,
		OPC_RW    = 4'h8,
		OPC_BAD   = 4'h9
	} rsd_op_e;
	function automatic rsd_op_e rsd_decode(input logic [7:0] op);
		if ((op & REL_MASK) == OP_REL) return OPC_REL;
		if (op == OP_SEEK) return OPC_SEEK;
		if (op == OP_RECAL) return OPC_RECAL;
		if (op == OP_DUMP) return OPC_DUMP;
		if (op == OP_SENSE) return OPC_SENSE;
		if (op == OP_SPECIFY) return OPC_SPEC;
		if (op == OP_CONFIG) return OPC_CONF;
		if ((op & LOW5_MASK) == OP_FORMAT) return OPC_FMT;
		if ((op & LOW5_MASK) == OP_READ || (op & LOW5_MASK) == OP_WRITE) return OPC_RW;
		return OPC_BAD;
	endfunction
	// ----------------------------------------------------------------
	// result status byte, result lengths and command buffer indices
	// ----------------------------------------------------------------
	localparam logic [1:0] IC_NORMAL  = 2'h0;
	localparam logic [1:0] IC_ABORT   = 2'h1;
	localparam logic [1:0] IC_INVALID = 2'h2;
	localparam logic [1:0] IC_READY   = 2'h3;
	localparam int         DUMP_LEN   = 10;
	localparam int         SENSE_LEN  = 2;
	localparam int         CMD_DEPTH  = 9;
	localparam int         FMT_SC_IDX = 3;
	localparam int         RW_EOT_IDX = 6;
	// ----------------------------------------------------------------
	// reset values and engines
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG1_RST   = 8'h60;
	localparam logic [7:0] CFG2_RST   = 8'h20;
	localparam logic [7:0] CFG3_RST   = 8'h00;
	localparam logic [7:0] SPEC_RST   = 8'h00;
	localparam logic [8:0] RECAL_MAX  = 9'h100;
	localparam int         ENG_ABS    = 0;
	localparam int         ENG_REL    = 1;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int SETTLE_NS      = 100;
	localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_WIDTH_NS  = 1000;
	localparam int STEP_WIDTH_CYC = (STEP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_PERIOD_US = 3000;
	localparam int TIMER_W        = 24;
	// ----------------------------------------------------------------
	// host register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CMD    = 4'h0;
	localparam logic [3:0] ADR_RES    = 4'h4;
	localparam logic [3:0] ADR_STAT   = 4'h8;
endpackage

// File: verilog/rsd_if.sv
// byte link between the host end and the controller end
// assumes both ends on the same clock
`timescale 1ns/100ps
interface rsd_if;
	logic       cmd_valid;
	logic       cmd_ready;
	logic [7:0] cmd_data;
	logic       res_valid;
	logic       res_ready;
	logic [7:0] res_data;
	modport dev  (input cmd_valid, cmd_data, res_ready, output cmd_ready, res_valid, res_data);
	modport host (output cmd_valid, cmd_data, res_ready, input cmd_ready, res_valid, res_data);
endinterface

// File: verilog/rsd_device.sv
// controller end: command parser, step engines, result bytes
// assumes drive pins come from outside the clock domain
// Operation
// - relative opcode: seek code, msb set, dir bit6
// - direction 0 steps out, 1 steps in
// - issue exactly count pulses unless track zero or ready loss stops them, no compare
// - move count even past track register limits
// - host keeps one relative step active
// - relative engine runs beside seek and rehome
// - outward past track zero sets equipment fault
// - track register becomes old plus or minus count mod256, or 0 on a track zero fault
// - one command moves at most 256 tracks
// - later commands use wrapped track value
// - rehome limited to 256 pulses, else error
// - host retries rehome after limit error
// - host handles tracks above 255 itself
// - host computes track difference for steps
// - dump returns tracks then timing and config
// - dump gives sectors after format, else eot
// - status only as command result bytes
// - termination code in status bits 7:6
// - seek end bit after seek or rehome
// - rehome without track zero sets fault
// - ready loss sets not ready bit
// - status low bits give head and drive
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module rsd_device #(
	parameter int STEP_PERIOD_CYC = rsd_pkg::STEP_PERIOD_US * 1000 / rsd_pkg::CLK_PERIOD_NS
)(
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	rsd_if.dev              bus,
	input  wire logic       i_track_zero,
	input  wire logic       i_drive_ready,
	output logic            o_step,
	output logic            o_step_in,
	output logic [1:0]      o_drive_sel,
	output logic            o_head_sel
);
	typedef enum logic [1:0] {PH_CMD = 2'h0, PH_EXEC = 2'h1, PH_RES = 2'h2} rsd_ph_e;
	typedef enum logic [1:0] {SL_IDLE = 2'h0, SL_SETTLE = 2'h1, SL_PULSE = 2'h2, SL_GAP = 2'h3} rsd_slot_e;
	localparam int TW = rsd_pkg::TIMER_W;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] cmd_len(input logic [7:0] op);
		case (rsd_pkg::rsd_decode(op))
			rsd_pkg::OPC_SEEK:  return 4'h3;
			rsd_pkg::OPC_REL:   return 4'h3;
			rsd_pkg::OPC_RECAL: return 4'h2;
			rsd_pkg::OPC_SPEC:  return 4'h3;
			rsd_pkg::OPC_CONF:  return 4'h4;
			rsd_pkg::OPC_FMT:   return 4'h6;
			rsd_pkg::OPC_RW:    return 4'h9;
			default:            return 4'h1;
		endcase
	endfunction
	function automatic logic [7:0] st0(input logic [1:0] ic, input logic se, input logic ec,
		input logic nr, input logic hd, input logic [1:0] ds);
		return {ic, se, ec, nr, hd, ds};
	endfunction
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rsd_ph_e    ph_reg;
	rsd_slot_e  slot_reg;
	logic [7:0] cbuf_reg [0:rsd_pkg::CMD_DEPTH-1];
	logic [3:0] ccnt_reg;
	logic [7:0] rbuf_reg [0:rsd_pkg::DUMP_LEN-1];
	logic [3:0] rcnt_reg;
	logic       cmd_ready_reg;
	logic       res_valid_reg;
	logic [7:0] spec1_reg, spec2_reg, sc_reg, eot_reg, cfg1_reg, cfg2_reg, cfg3_reg;
	logic       last_fmt_reg;
	logic [1:0] start_reg, sclr_reg, st_drv_reg;
	logic       st_hd_reg, st_recal_reg, st_in_reg;
	logic [7:0] st_cnt_reg;
	logic [1:0] act_reg, recal_reg, in_reg, hd_reg, pend_reg;
	logic [1:0] drv_reg  [0:1];
	logic [8:0] rem_reg  [0:1];
	logic [7:0] tgt_reg  [0:1];
	logic [7:0] pst0_reg [0:1];
	logic [7:0] pcn_reg  [0:3];
	logic [TW-1:0] timer_reg;
	logic       g_reg, pick;
	logic       tz_s1_reg, tz_reg, rdy_s1_reg, rdy_reg;
	logic [7:0] b0;
	assign b0 = cbuf_reg[0];
	assign pick = act_reg[1] && (!act_reg[0] || !g_reg);
	assign bus.cmd_ready = cmd_ready_reg;
	assign bus.res_valid = res_valid_reg;
	assign bus.res_data  = rbuf_reg[0];
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		tz_s1_reg  <= i_track_zero;
		tz_reg     <= tz_s1_reg;
		rdy_s1_reg <= i_drive_ready;
		rdy_reg    <= rdy_s1_reg;
	end
	// ----------------------------------------------------------------
	// command parser and result bytes
	// ----------------------------------------------------------------
	task automatic put1(input logic [7:0] b);
		rbuf_reg[0]   <= b;
		rcnt_reg      <= 4'h1;
		res_valid_reg <= 1'b1;
		cmd_ready_reg <= 1'b0;
		ph_reg        <= PH_RES;
	endtask
	task automatic go(input int e, input logic recal, input logic dir);
		start_reg[e] <= 1'b1;
		st_drv_reg   <= cbuf_reg[1][1:0];
		st_hd_reg    <= cbuf_reg[1][2];
		st_recal_reg <= recal;
		st_in_reg    <= dir;
		st_cnt_reg   <= cbuf_reg[2];
	endtask
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ph_reg <= PH_CMD;
			ccnt_reg <= 4'h0;
			rcnt_reg <= 4'h0;
			cmd_ready_reg <= 1'b1;
			res_valid_reg <= 1'b0;
			start_reg <= 2'h0;
			sclr_reg <= 2'h0;
			{spec1_reg, spec2_reg, sc_reg, eot_reg} <= {4{rsd_pkg::SPEC_RST}};
			cfg1_reg <= rsd_pkg::CFG1_RST;
			cfg2_reg <= rsd_pkg::CFG2_RST;
			cfg3_reg <= rsd_pkg::CFG3_RST;
			last_fmt_reg <= 1'b0;
			{st_drv_reg, st_hd_reg, st_recal_reg, st_in_reg, st_cnt_reg} <= 13'h0000;
			for (int i = 0; i < rsd_pkg::DUMP_LEN; i++) rbuf_reg[i] <= 8'h00;
			for (int i = 0; i < rsd_pkg::CMD_DEPTH; i++) cbuf_reg[i] <= 8'h00;
		end
		else
		begin
			start_reg <= 2'h0;
			sclr_reg <= 2'h0;
			case (ph_reg)
				PH_CMD:
					if (bus.cmd_valid && cmd_ready_reg)
					begin
						cbuf_reg[ccnt_reg] <= bus.cmd_data;
						if (4'(ccnt_reg + 4'h1) == cmd_len(ccnt_reg == 4'h0 ? bus.cmd_data : b0))
						begin
							ccnt_reg <= 4'h0;
							cmd_ready_reg <= 1'b0;
							ph_reg <= PH_EXEC;
						end
						else
							ccnt_reg <= 4'(ccnt_reg + 4'h1);
					end
				PH_EXEC:
				begin
					ph_reg <= PH_CMD;
					cmd_ready_reg <= 1'b1;
					case (rsd_pkg::rsd_decode(b0))
						rsd_pkg::OPC_SEEK, rsd_pkg::OPC_RECAL:
							if (act_reg[rsd_pkg::ENG_ABS])
								put1(st0(rsd_pkg::IC_INVALID, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
							else
								go(rsd_pkg::ENG_ABS, b0 == rsd_pkg::OP_RECAL, 1'b0);
						rsd_pkg::OPC_REL:
							if (act_reg[rsd_pkg::ENG_REL])
								put1(st0(rsd_pkg::IC_INVALID, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
							else
								go(rsd_pkg::ENG_REL, 1'b0, b0[rsd_pkg::REL_DIR]);
						rsd_pkg::OPC_DUMP:
						begin
							for (int i = 0; i < 4; i++) rbuf_reg[i] <= pcn_reg[i];
							rbuf_reg[4] <= spec1_reg;
							rbuf_reg[5] <= spec2_reg;
							rbuf_reg[6] <= last_fmt_reg ? sc_reg : eot_reg;
							rbuf_reg[7] <= cfg1_reg;
							rbuf_reg[8] <= cfg2_reg;
							rbuf_reg[9] <= cfg3_reg;
							rcnt_reg <= 4'(rsd_pkg::DUMP_LEN);
							res_valid_reg <= 1'b1;
							cmd_ready_reg <= 1'b0;
							ph_reg <= PH_RES;
						end
						rsd_pkg::OPC_SENSE:
							if (pend_reg != 2'h0)
							begin
								rbuf_reg[0] <= pend_reg[0] ? pst0_reg[0] : pst0_reg[1];
								rbuf_reg[1] <= pend_reg[0] ? pcn_reg[drv_reg[0]] : pcn_reg[drv_reg[1]];
								sclr_reg <= pend_reg[0] ? 2'h1 : 2'h2;
								rcnt_reg <= 4'(rsd_pkg::SENSE_LEN);
								res_valid_reg <= 1'b1;
								cmd_ready_reg <= 1'b0;
								ph_reg <= PH_RES;
							end
							else
								put1(st0(rsd_pkg::IC_INVALID, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
						rsd_pkg::OPC_SPEC:
						begin
							spec1_reg <= cbuf_reg[1];
							spec2_reg <= cbuf_reg[2];
						end
						rsd_pkg::OPC_CONF:
						begin
							cfg1_reg <= cbuf_reg[1];
							cfg2_reg <= cbuf_reg[2];
							cfg3_reg <= cbuf_reg[3];
						end
						rsd_pkg::OPC_FMT, rsd_pkg::OPC_RW:
						begin
							// media transfer is not built here; parameters are kept for the dump
							last_fmt_reg <= rsd_pkg::rsd_decode(b0) == rsd_pkg::OPC_FMT;
							if (rsd_pkg::rsd_decode(b0) == rsd_pkg::OPC_FMT)
								sc_reg <= cbuf_reg[rsd_pkg::FMT_SC_IDX];
							else
								eot_reg <= cbuf_reg[rsd_pkg::RW_EOT_IDX];
							put1(st0(rsd_pkg::IC_ABORT, 1'b0, 1'b0, 1'b0, cbuf_reg[1][2], cbuf_reg[1][1:0]));
						end
						default:
							put1(st0(rsd_pkg::IC_INVALID, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
					endcase
				end
				PH_RES:
					if (bus.res_ready && res_valid_reg)
					begin
						for (int i = 0; i < rsd_pkg::DUMP_LEN - 1; i++) rbuf_reg[i] <= rbuf_reg[i+1];
						rcnt_reg <= 4'(rcnt_reg - 4'h1);
						if (rcnt_reg == 4'h1)
						begin
							res_valid_reg <= 1'b0;
							cmd_ready_reg <= 1'b1;
							ph_reg <= PH_CMD;
						end
					end
				default:
					ph_reg <= PH_CMD;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// step engines sharing one step pin
	// ----------------------------------------------------------------
	task automatic fin(input logic [1:0] ic, input logic se, input logic ec, input logic nr,
		input logic upd, input logic [7:0] np);
		act_reg[g_reg] <= 1'b0;
		pend_reg[g_reg] <= 1'b1; // set after clear, so it wins
		pst0_reg[g_reg] <= st0(ic, se, ec, nr, hd_reg[g_reg], drv_reg[g_reg]);
		if (upd) pcn_reg[drv_reg[g_reg]] <= np;
		slot_reg <= SL_IDLE;
	endtask
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			slot_reg <= SL_IDLE;
			timer_reg <= '0;
			g_reg <= 1'b0;
			{o_step, o_step_in, o_drive_sel, o_head_sel} <= 5'h00;
			{act_reg, recal_reg, in_reg, hd_reg, pend_reg} <= 10'h000;
			for (int e = 0; e < 2; e++)
			begin
				drv_reg[e] <= 2'h0;
				rem_reg[e] <= 9'h000;
				tgt_reg[e] <= 8'h00;
				pst0_reg[e] <= 8'h00;
			end
			for (int d = 0; d < 4; d++) pcn_reg[d] <= 8'h00;
		end
		else
		begin
			for (int e = 0; e < 2; e++)
			begin
				if (sclr_reg[e]) pend_reg[e] <= 1'b0;
				if (start_reg[e])
				begin
					act_reg[e] <= 1'b1;
					recal_reg[e] <= st_recal_reg;
					drv_reg[e] <= st_drv_reg;
					hd_reg[e] <= st_hd_reg;
					if (st_recal_reg)
					begin
						in_reg[e] <= 1'b0;
						rem_reg[e] <= rsd_pkg::RECAL_MAX;
					end
					else if (e == rsd_pkg::ENG_REL)
					begin
						in_reg[e] <= st_in_reg;
						rem_reg[e] <= {1'b0, st_cnt_reg};
						tgt_reg[e] <= st_in_reg ? 8'(pcn_reg[st_drv_reg] + st_cnt_reg)
							: 8'(pcn_reg[st_drv_reg] - st_cnt_reg);
					end
					else
					begin
						in_reg[e] <= st_cnt_reg > pcn_reg[st_drv_reg];
						rem_reg[e] <= {1'b0, st_cnt_reg > pcn_reg[st_drv_reg]
							? 8'(st_cnt_reg - pcn_reg[st_drv_reg]) : 8'(pcn_reg[st_drv_reg] - st_cnt_reg)};
						tgt_reg[e] <= st_cnt_reg;
					end
				end
			end
			case (slot_reg)
				SL_IDLE:
					if (act_reg != 2'h0)
					begin
						g_reg <= pick;
						o_drive_sel <= drv_reg[pick];
						o_head_sel <= hd_reg[pick];
						o_step_in <= in_reg[pick];
						timer_reg <= '0;
						slot_reg <= SL_SETTLE;
					end
				SL_SETTLE:
					if (timer_reg != TW'(rsd_pkg::SETTLE_CYC - 1))
						timer_reg <= TW'(timer_reg + 1'b1);
					else if (!rdy_reg)
						fin(rsd_pkg::IC_READY, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
					else if (recal_reg[g_reg] && tz_reg)
						fin(rsd_pkg::IC_NORMAL, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
					else if (g_reg && !in_reg[g_reg] && tz_reg && rem_reg[g_reg] != 9'h000)
						fin(rsd_pkg::IC_ABORT, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
					else if (rem_reg[g_reg] == 9'h000)
					begin
						if (recal_reg[g_reg])
							fin(rsd_pkg::IC_ABORT, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
						else
							fin(rsd_pkg::IC_NORMAL, !g_reg, 1'b0, 1'b0, 1'b1, tgt_reg[g_reg]);
					end
					else
					begin
						o_step <= 1'b1;
						rem_reg[g_reg] <= 9'(rem_reg[g_reg] - 9'h001);
						timer_reg <= '0;
						slot_reg <= SL_PULSE;
					end
				SL_PULSE:
					if (timer_reg != TW'(rsd_pkg::STEP_WIDTH_CYC - 1))
						timer_reg <= TW'(timer_reg + 1'b1);
					else
					begin
						o_step <= 1'b0;
						timer_reg <= '0;
						slot_reg <= SL_GAP;
					end
				SL_GAP:
					if (timer_reg != TW'(STEP_PERIOD_CYC - 1))
						timer_reg <= TW'(timer_reg + 1'b1);
					else
						slot_reg <= SL_IDLE;
				default:
					slot_reg <= SL_IDLE;
			endcase
		end
	end
endmodule // rsd_device

// File: verilog/rsd_host.sv
// host end: classic wishbone slave that feeds command bytes and pops results
// assumes software keeps command ordering and track arithmetic
`timescale 1ns/100ps
module rsd_host (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	rsd_if.host              bus,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack
);
	logic       cmd_valid_reg;
	logic [7:0] cmd_data_reg;
	logic       res_ready_reg;
	assign bus.cmd_valid = cmd_valid_reg;
	assign bus.cmd_data  = cmd_data_reg;
	assign bus.res_ready = res_ready_reg;
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			cmd_valid_reg <= 1'b0;
			cmd_data_reg <= 8'h00;
			res_ready_reg <= 1'b0;
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end
		else
		begin
			o_wb_ack <= 1'b0;
			res_ready_reg <= 1'b0;
			if (cmd_valid_reg && bus.cmd_ready)
				cmd_valid_reg <= 1'b0;
			if (i_wb_cyc && i_wb_stb && !o_wb_ack)
			begin
				o_wb_ack <= 1'b1;
				o_wb_dat <= 32'h0000_0000;
				case (i_wb_adr)
					rsd_pkg::ADR_CMD:
						// bytes go out untouched; track arithmetic and retries stay in software
						if (i_wb_we && i_wb_sel[0] && !cmd_valid_reg)
						begin
							cmd_valid_reg <= 1'b1;
							cmd_data_reg <= i_wb_dat[7:0];
						end
					rsd_pkg::ADR_RES:
						if (!i_wb_we && bus.res_valid)
						begin
							o_wb_dat <= {24'h00_0000, bus.res_data};
							res_ready_reg <= 1'b1;
						end
					rsd_pkg::ADR_STAT:
						if (!i_wb_we)
							o_wb_dat <= {30'h0000_0000, bus.res_valid, cmd_valid_reg};
					default:
						o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // rsd_host

// File: sim/rsd_assertions.sv
// checker for the byte link and the drive step pins
// assumes one clock; instantiated beside the link, fed by name
`timescale 1ns/100ps
module rsd_assertions (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_data,
	input wire logic       res_valid,
	input wire logic       res_ready,
	input wire logic [7:0] res_data,
	input wire logic       o_step,
	input wire logic       o_step_in,
	input wire logic [1:0] o_drive_sel,
	input wire logic       o_head_sel
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic       first_reg;
	logic [7:0] op_reg;
	logic [7:0] pop_reg;
	logic [8:0] high_reg;
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// next byte is an opcode once the device has dropped ready after a command
	always_ff @(posedge i_clk)
		if (i_reset || !cmd_ready) first_reg <= 1'b1;
		else if (cmd_valid) first_reg <= 1'b0;
	always_ff @(posedge i_clk)
		if (i_reset) op_reg <= 8'h00;
		else if (cmd_valid && cmd_ready && first_reg) op_reg <= cmd_data;
	always_ff @(posedge i_clk)
		if (i_reset || (cmd_valid && cmd_ready)) pop_reg <= 8'h00;
		else if (res_valid && res_ready) pop_reg <= pop_reg + 8'h01;
	always_ff @(posedge i_clk)
		if (i_reset || !o_step) high_reg <= 9'h000;
		else high_reg <= high_reg + 9'h001;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_bad_op;
		cmd_valid && cmd_ready && first_reg && cmd_data == 8'hFF;
	endsequence
	sequence s_refusal;
		##[1:3] (res_valid && res_data == 8'h80);
	endsequence
	AST_BAD_OP: assert property (s_bad_op |-> s_refusal) else $error("invalid opcode not refused");
	AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data)) else $error("command byte moved");
	AST_RES_HOLD: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data)) else $error("result byte moved");
	AST_RES_BLOCK: assert property (res_valid |-> !cmd_ready) else $error("command taken with results pending");
	AST_DUMP_LEN: assert property ($fell(res_valid) && op_reg == rsd_pkg::OP_DUMP |-> pop_reg == 8'(rsd_pkg::DUMP_LEN)) else $error("dump length wrong");
	AST_STEP_WIDTH: assert property ($fell(o_step) |-> high_reg == 9'(rsd_pkg::STEP_WIDTH_CYC)) else $error("step pulse width wrong");
	AST_SEL_SETTLE: assert property ($rose(o_step) |-> $past(o_drive_sel, 8) == o_drive_sel && $past(o_step_in, 8) == o_step_in) else $error("select not settled");
	AST_PULSE_STABLE: assert property (o_step |=> !o_step || ($stable(o_step_in) && $stable(o_drive_sel) && $stable(o_head_sel))) else $error("pins moved in pulse");
endmodule // rsd_assertions

// File: sim/relative_seek_and_state_dump_bench.sv
// bench: wishbone host end joined to the controller end over the link
// assumes a drive whose head position is modelled here from the step pins
`timescale 1ns/100ps
module relative_seek_and_state_dump_bench;
	typedef struct {logic [7:0] op, sel, cnt, st0, trk; int pul, phy;} rsd_row_s;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, r;
	logic        ack, step, step_in, head, head_seen;
	logic        track_zero_input = 1'b1;
	logic        rdy = 1'b1;
	logic [3:0]  sel = 4'hF;
	logic [1:0]  dsel;
	logic [7:0]  res [16];
	logic [7:0]  st0, trk;
	int          nres, pulses;
	int          miscompares = 0;
	int          cmp_count = 0;
	// drive 3 starts beyond the rehome pulse limit
	int          phys [4] = '{0, 5, 0, 257};
	rsd_row_s    rows [6] = '{
		'{8'hCF, 8'h00, 8'h03, 8'h00, 8'h03, 3, 3},
		'{8'h8F, 8'h04, 8'h01, 8'h04, 8'h02, 1, 2},
		'{8'h8F, 8'h01, 8'h03, 8'h01, 8'hFD, 3, 2},
		'{8'h8F, 8'h06, 8'h02, 8'h56, 8'h00, 0, 0},
		'{8'hCF, 8'h02, 8'h00, 8'h02, 8'h00, 0, 0},
		'{8'h0F, 8'h00, 8'h06, 8'h20, 8'h06, 4, 6}};
	rsd_if link ();
	rsd_device #(.STEP_PERIOD_CYC(10)) rsd_device_i (.i_clk(i_clk), .i_reset(i_reset), .bus(link),
		.i_track_zero(track_zero_input), .i_drive_ready(rdy), .o_step(step), .o_step_in(step_in), .o_drive_sel(dsel),
		.o_head_sel(head));
	rsd_host rsd_host_i (.i_clk(i_clk), .i_reset(i_reset), .bus(link), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack));
	rsd_assertions rsd_assertions_i (.i_clk(i_clk), .i_reset(i_reset), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data), .res_valid(link.res_valid),
		.res_ready(link.res_ready), .res_data(link.res_data), .o_step(step), .o_step_in(step_in),
		.o_drive_sel(dsel), .o_head_sel(head));
	always #2.5 i_clk = ~i_clk;
	// ----------------------------------------------------------------
	// drive model and bus tasks
	// ----------------------------------------------------------------
	always @(posedge step)
	begin
		pulses++;
		head_seen = head;
		if (step_in) phys[dsel]++;
		else if (phys[dsel] > 0) phys[dsel]--;
	end
	always @(posedge i_clk) track_zero_input <= (phys[dsel] == 0);
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		wrap_up();
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp);
		cmp_count++;
		if (got != exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		for (n = 0; n < 20; n++)
		begin
			@(posedge i_clk);
			if (ack === 1'b1) break;
		end
		if (n >= 20) hang();
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// bit 0 waits for the byte slot to empty, bit 1 for a result
	task automatic poll(input int b);
		int n;
		wb(1'b0, rsd_pkg::ADR_STAT, 8'h00);
		for (n = 0; n < 50 && r[b] !== (b == 1); n++) wb(1'b0, rsd_pkg::ADR_STAT, 8'h00);
		if (n >= 50) hang();
	endtask
	task automatic cmd(input logic [7:0] q [$]);
		foreach (q[i])
		begin
			poll(0);
			wb(1'b1, rsd_pkg::ADR_CMD, q[i]);
		end
	endtask
	task automatic collect();
		nres = 0;
		poll(1);
		while (r[1] === 1'b1 && nres < 16)
		begin
			wb(1'b0, rsd_pkg::ADR_RES, 8'h00);
			res[nres] = r[7:0];
			nres++;
			wb(1'b0, rsd_pkg::ADR_STAT, 8'h00);
		end
	endtask
	// a lone refusal byte means nothing finished yet; slow but no timing guess
	task automatic sense();
		int n;
		for (n = 0; n < 6000; n++)
		begin
			cmd('{rsd_pkg::OP_SENSE});
			collect();
			if (nres == 2) break;
		end
		if (n >= 6000) hang();
		st0 = res[0];
		trk = res[1];
	endtask
	task automatic dump(input logic [7:0] e [10]);
		cmd('{rsd_pkg::OP_DUMP});
		collect();
		chkn(nres, rsd_pkg::DUMP_LEN);
		for (int i = 0; i < 10; i++) chk8(res[i], e[i]);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		foreach (rows[k])
		begin
			pulses = 0;
			cmd('{rows[k].op, rows[k].sel, rows[k].cnt});
			sense();
			chk8(st0, rows[k].st0);
			chk8(trk, rows[k].trk);
			chkn(pulses, rows[k].pul);
			chkn(phys[rows[k].sel[1:0]], rows[k].phy);
			if (rows[k].pul > 0) chk8({7'h00, head_seen}, {7'h00, rows[k].sel[2]});
		end
		pulses = 0;
		cmd('{rsd_pkg::OP_RECAL, 8'h03});
		cmd('{8'hCF, 8'h00, 8'h02});
		cmd('{8'hCF, 8'h00, 8'h01});
		collect();
		chk8(res[0], 8'h80);
		// a seek while rehome holds the absolute engine is turned away
		cmd('{rsd_pkg::OP_SEEK, 8'h00, 8'h01});
		collect();
		chk8(res[0], 8'h80);
		cmd('{8'hFF});
		collect();
		chkn(nres, 1);
		chk8(res[0], 8'h80);
		sense();
		chk8(st0, 8'h00);
		chk8(trk, 8'h08);
		sense();
		chk8(st0, 8'h73);
		chk8(trk, 8'h00);
		chkn(pulses, 258);
		cmd('{rsd_pkg::OP_RECAL, 8'h03});
		sense();
		chk8(st0, 8'h23);
		chkn(phys[3], 0);
		rdy <= 1'b0;
		cmd('{8'hCF, 8'h00, 8'h03});
		sense();
		rdy <= 1'b1;
		chk8(st0, 8'hC8);
		chk8(trk, 8'h08);
		cmd('{rsd_pkg::OP_FORMAT, 8'h00, 8'h02, 8'h12, 8'h1B, 8'hE5});
		collect();
		chk8(res[0], 8'h40);
		cmd('{rsd_pkg::OP_SPECIFY, 8'hAB, 8'hCD});
		cmd('{rsd_pkg::OP_CONFIG, 8'h0A, 8'h4B, 8'h05});
		dump('{8'h08, 8'hFD, 8'h00, 8'h00, 8'hAB, 8'hCD, 8'h12, 8'h0A, 8'h4B, 8'h05});
		cmd('{rsd_pkg::OP_READ, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1B, 8'hFF});
		collect();
		chk8(res[0], 8'h40);
		dump('{8'h08, 8'hFD, 8'h00, 8'h00, 8'hAB, 8'hCD, 8'h09, 8'h0A, 8'h4B, 8'h05});
		cmd('{rsd_pkg::OP_WRITE, 8'h05, 8'h00, 8'h00, 8'h01, 8'h02, 8'h0C, 8'h1B, 8'hFF});
		collect();
		chk8(res[0], 8'h45);
		dump('{8'h08, 8'hFD, 8'h00, 8'h00, 8'hAB, 8'hCD, 8'h0C, 8'h0A, 8'h4B, 8'h05});
		i_reset <= 1'b1;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		// a command write without byte lane 0 must be dropped
		sel <= 4'hE;
		wb(1'b1, rsd_pkg::ADR_CMD, 8'hFF);
		sel <= 4'hF;
		wb(1'b0, rsd_pkg::ADR_STAT, 8'h00);
		chk8(r[7:0], 8'h00);
		wb(1'b0, rsd_pkg::ADR_RES, 8'h00);
		chk8(r[7:0], 8'h00);
		wb(1'b0, 4'hC, 8'h00);
		chk8(r[7:0], 8'h00);
		dump('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h20, 8'h00});
		wrap_up();
	end
endmodule // relative_seek_and_state_dump_bench
